// File: inc/bslc_regs.vh
`ifndef BSLC_REGS_VH
`define BSLC_REGS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BSLC_SETTINGS_ADDR 6'h1A
`define BSLC_SETTINGS_RESET 8'h6C
// Loop gains presented while reset holds, matching the reset settings
`define BSLC_KI_RESET 4'h4
`define BSLC_KP_RESET 3'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BSLC_PRE_KI_HI 7
`define BSLC_PRE_KI_LO 6
`define BSLC_PRE_KP_HI 5
`define BSLC_PRE_KP_LO 4
`define BSLC_POST_KI_BIT 3
`define BSLC_POST_KP_BIT 2
`define BSLC_LIMIT_HI 1
`define BSLC_LIMIT_LO 0

// ----------------------------------------
// Gain codes presented to the loop
// ----------------------------------------
// Integral gain in half steps of K_I: 1 = K_I/2, 2 = K_I ... 8 = 4K_I
`define BSLC_KI_HALF 4'h1
// Proportional gain in steps of K_P: 1 = K_P ... 4 = 4K_P
`define BSLC_KP_ONE 3'h1

// ----------------------------------------
// Rate offset limit, in 1/32 steps of the data rate
// ----------------------------------------
`define BSLC_LIMIT_OFF 3'h0
`define BSLC_LIMIT_3P125 3'h1
`define BSLC_LIMIT_6P25 3'h2
`define BSLC_LIMIT_12P5 3'h4

`endif

// File: hdl/bslc_gain_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "bslc_regs.vh"

module bslc_gain_decode (
    // Register fields
    input wire [7:0] settings,
    input wire synced,
    // Decoded loop controls
    output reg [3:0] ki_half_steps,
    output reg [2:0] kp_steps,
    output reg [2:0] limit_32nds
);
    reg [3:0] pre_ki;
    reg [2:0] pre_kp;

    always @* begin
        // Pre-sync integral gain 1..4 K_I, held in half steps
        pre_ki = {1'b0, settings[`BSLC_PRE_KI_HI:`BSLC_PRE_KI_LO], 1'b0}
            + 4'h2;
        pre_kp = {1'b0, settings[`BSLC_PRE_KP_HI:`BSLC_PRE_KP_LO]}
            + 3'h1;
        ki_half_steps = pre_ki;
        kp_steps = pre_kp;
        if (synced) begin
            if (settings[`BSLC_POST_KI_BIT]) begin
                ki_half_steps = `BSLC_KI_HALF;
            end
            if (settings[`BSLC_POST_KP_BIT]) begin
                kp_steps = `BSLC_KP_ONE;
            end
        end
        case (settings[`BSLC_LIMIT_HI:`BSLC_LIMIT_LO])
            2'h0: limit_32nds = `BSLC_LIMIT_OFF;
            2'h1: limit_32nds = `BSLC_LIMIT_3P125;
            2'h2: limit_32nds = `BSLC_LIMIT_6P25;
            default: limit_32nds = `BSLC_LIMIT_12P5;
        endcase
    end
endmodule
`default_nettype wire

// File: hdl/bslc_config.v
`timescale 1ns/100ps
`default_nettype none
`include "bslc_regs.vh"

module bslc_config (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Register access from the serial interface
    input wire [5:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_reg,
    // Clock recovery loop status
    input wire sync_detected,
    input wire sync_search_start,
    // Loop controls
    output reg [3:0] integral_gain_reg,
    output reg [2:0] proportional_gain_reg,
    output reg [2:0] rate_limit_reg,
    output reg loop_enable_reg
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------
    // Settings register
    // ----------------------------------------
    reg [7:0] bit_sync_loop_settings_reg;
    reg synced_reg;
    reg synced_next;
    wire [3:0] ki_dec;
    wire [2:0] kp_dec;
    wire [2:0] lim_dec;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bit_sync_loop_settings_reg <= `BSLC_SETTINGS_RESET;
        end else if (!rst_sync_reg) begin
            bit_sync_loop_settings_reg <= `BSLC_SETTINGS_RESET;
        end else if (reg_wr && reg_addr == `BSLC_SETTINGS_ADDR) begin
            bit_sync_loop_settings_reg <= reg_wdata;
        end
    end

    // Unmapped addresses read zero; data is registered one cycle late
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_addr == `BSLC_SETTINGS_ADDR) begin
            reg_rdata_reg <= bit_sync_loop_settings_reg;
        end else begin
            reg_rdata_reg <= 8'h00;
        end
    end

    // ----------------------------------------
    // Search / synced phase
    // ----------------------------------------
    // A restart wins over a detection in the same cycle, so a fresh
    // search never begins on the slow post-sync gains.
    always @* begin
        synced_next = synced_reg;
        if (sync_search_start) begin
            synced_next = 1'b0;
        end else if (sync_detected) begin
            synced_next = 1'b1;
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            synced_reg <= 1'b0;
        end else if (!rst_sync_reg) begin
            synced_reg <= 1'b0;
        end else begin
            synced_reg <= synced_next;
        end
    end

    bslc_gain_decode u_decode (
        .settings(bit_sync_loop_settings_reg),
        .synced(synced_next),
        .ki_half_steps(ki_dec),
        .kp_steps(kp_dec),
        .limit_32nds(lim_dec)
    );

    // ----------------------------------------
    // Registered loop controls
    // ----------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            integral_gain_reg <= `BSLC_KI_RESET;
            proportional_gain_reg <= `BSLC_KP_RESET;
            rate_limit_reg <= `BSLC_LIMIT_OFF;
            loop_enable_reg <= 1'b0;
        end else begin
            integral_gain_reg <= ki_dec;
            proportional_gain_reg <= kp_dec;
            rate_limit_reg <= lim_dec;
            loop_enable_reg <= (lim_dec != `BSLC_LIMIT_OFF);
        end
    end
endmodule
`default_nettype wire

// File: tb/bslc_config_sva.sv
`timescale 1ns/100ps
`default_nettype none
module bslc_config_sva (
    input wire core_clk, rstn, reg_wr, sync_detected, sync_search_start,
    input wire [3:0] integral_gain_reg,
    input wire [2:0] proportional_gain_reg, rate_limit_reg,
    input wire loop_enable_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_quiet;
        !reg_wr && !sync_detected && !sync_search_start;
    endsequence
    a_reset_gains: assert property (disable iff (1'b0)
        !rstn |-> integral_gain_reg == 4'h4 && rate_limit_reg == 3'h0
        && proportional_gain_reg == 3'h3) else $error("reset");
    a_quiet_hold: assert property (s_quiet [*3] |->
        $stable({integral_gain_reg, proportional_gain_reg, rate_limit_reg}))
        else $error("drift");
    a_enable_limit: assert property (
        loop_enable_reg == (rate_limit_reg != 3'h0)) else $error("enable");
    a_limit_code: assert property (
        rate_limit_reg inside {3'h0, 3'h1, 3'h2, 3'h4}) else $error("limit");
    a_ki_code: assert property (
        integral_gain_reg inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
        else $error("ki");
    a_kp_code: assert property (
        proportional_gain_reg inside {[3'h1:3'h4]}) else $error("kp");
endmodule
bind bslc_config bslc_config_sva u_sva (.core_clk, .rstn, .reg_wr,
    .sync_detected, .sync_search_start, .integral_gain_reg,
    .proportional_gain_reg, .rate_limit_reg, .loop_enable_reg);
`default_nettype wire

// File: tb/bslc_host.sv
`timescale 1ns/100ps
`default_nettype none
module bslc_host (
    input wire logic core_clk,
    output var logic [5:0] reg_addr = 6'h00,
    output var logic reg_wr = 1'b0,
    output var logic [7:0] reg_wdata = 8'h00
);
    // Released data shows the inverse, never a stale copy
    task xfer(input [5:0] a, input [7:0] d, input w);
        @(negedge core_clk);
        reg_addr = a;
        reg_wr = w;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// File: tb/test_bit_sync_loop_config.sv
`timescale 1ns/100ps
`default_nettype none
module test_bit_sync_loop_config;
    logic core_clk, rstn, reg_wr, sync_detected, sync_search_start;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_reg, s;
    logic [3:0] integral_gain_reg;
    logic [2:0] proportional_gain_reg, rate_limit_reg;
    logic loop_enable_reg;
    int error_cnt = 0, n_checks = 0;
    wire [10:0] g = {integral_gain_reg, proportional_gain_reg,
        rate_limit_reg, loop_enable_reg};
    bslc_host u_host (.core_clk, .reg_addr, .reg_wr, .reg_wdata);
    bslc_config u_dut (.core_clk, .rstn, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rdata_reg, .sync_detected, .sync_search_start,
        .integral_gain_reg, .proportional_gain_reg, .rate_limit_reg,
        .loop_enable_reg);
    function automatic [10:0] want(input [7:0] v, input p);
        logic [3:0] i;
        logic [2:0] k;
        case (v[7:6])
            2'h0: i = 4'h2;
            2'h1: i = 4'h4;
            2'h2: i = 4'h6;
            default: i = 4'h8;
        endcase
        k = 3'h1 + v[5:4];
        if (p && v[3]) i = 4'h1;
        if (p && v[2]) k = 3'h1;
        return {i, k, v[1:0] == 2'h3 ? 3'h4 : {1'b0, v[1:0]}, |v[1:0]};
    endfunction
    task chk(input string n, input [10:0] seen, e);
        n_checks++;
        if (seen !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", n, e, seen);
        end
    endtask
    task results;
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task pulse(input d, r);
        @(negedge core_clk);
        sync_detected = d;
        sync_search_start = r;
        @(negedge core_clk);
        sync_detected = 1'b0;
        sync_search_start = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        error_cnt++;
        results;
    end
    initial begin
        rstn = 1'b1;
        sync_detected = 1'b0;
        sync_search_start = 1'b0;
        void'($urandom(32'hF7D15D7C));
        // A real falling edge, so the reset gains stand at the first edge
        #1;
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        repeat (2) @(negedge core_clk);
        u_host.xfer(6'h1A, 8'h00, 1'b0);
        chk("reset", g, want(8'h6C, 1'b0));
        chk("rd_reset", reg_rdata_reg, 8'h6C);
        for (int n = 0; n < 40; n++) begin
            s = $urandom;
            if (n < 4) s[1:0] = n[1:0];
            u_host.xfer(6'h1A, s, 1'b1);
            u_host.xfer(6'h05, ~s, 1'b1);
            repeat (2) @(negedge core_clk);
            chk("rd_other", reg_rdata_reg, 8'h00);
            // Odd passes restart in the same cycle, which must win
            pulse(1'b1, n[0]);
            chk("phase", g, want(s, !n[0]));
            pulse(1'b0, 1'b1);
            chk("search", g, want(s, 1'b0));
            u_host.xfer(6'h1A, 8'h00, 1'b0);
            chk("rd_back", reg_rdata_reg, s);
        end
        // Mid-run reset while synced; a write at the second edge is refused
        pulse(1'b1, 1'b0);
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        u_host.xfer(6'h1A, 8'h03, 1'b1);
        u_host.xfer(6'h1A, 8'h00, 1'b0);
        chk("rst_mid", g, want(8'h6C, 1'b0));
        chk("rd_refused", reg_rdata_reg, 8'h6C);
        results;
    end
endmodule
`default_nettype wire
